// ==== pkg/bwpc_pkg.sv ====
/*
 power-state constants and carrier types for the board wake power controller.
 assumes one standby clock and a standby power-good reset.
*/
package bwpc_pkg;

	// sleep state encoding
	typedef enum logic [2:0]
	{
		BWPC_OFF = 3'h0,
		BWPC_S0 = 3'h1,
		BWPC_S3 = 3'h2,
		BWPC_S4 = 3'h3,
		BWPC_S5 = 3'h4
	} bwpc_state_t;

	// sleep command codes from the operating system
	localparam logic [1:0] BWPC_CMD_S3 = 2'h1;
	localparam logic [1:0] BWPC_CMD_S4 = 2'h2;
	localparam logic [1:0] BWPC_CMD_S5 = 2'h3;

	// restore policy codes
	localparam logic [1:0] BWPC_POL_OFF = 2'h0;
	localparam logic [1:0] BWPC_POL_ON = 2'h1;
	localparam logic [1:0] BWPC_POL_LAST = 2'h2;

	localparam int BWPC_NUM_WAKE = 6;
	localparam int BWPC_W_NET = 0;
	localparam int BWPC_W_PME = 1;
	localparam int BWPC_W_PCIE = 2;
	localparam int BWPC_W_USB = 3;
	localparam int BWPC_W_PS2 = 4;
	localparam int BWPC_W_BTN = 5;

	// raw wake pins, active low as on the board
	typedef struct packed
	{
		logic btn_n;
		logic ps2_n;
		logic usb_n;
		logic pcieWake_n;
		logic pme_n;
		logic net_n;
	} bwpc_wake_t;

	// configuration straps held in standby
	typedef struct packed
	{
		logic pm_event_wake_enable;
		logic softOffWakeEnable;
		logic [1:0] restorePolicy;
	} bwpc_cfg_t;

	// outputs to supply, fans and panel
	typedef struct packed
	{
		logic mainSupplyOn;
		logic fanOn;
		logic ledGreen;
		logic ledAmber;
		logic standbyLed;
	} bwpc_out_t;

endpackage : bwpc_pkg

// ==== design/bwpc_top.sv ====
/*
 board wake power controller: sleep state tracking, supply and fan control,
 wake arbitration, panel indication and ac-loss restore.
 assumes the standby clock and reset stay up in every state but mechanical off,
 and that ac return is reported by a level from the supply.
*/
`timescale 1ns/10ps
module bwpc_top
	import bwpc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire bwpc_wake_t wakePins,
	input wire logic sleepCmdValid,
	input wire logic [1:0] sleepCmd,
	input wire logic acPresent,
	input wire bwpc_cfg_t cfg,
	output bwpc_out_t outs,
	output logic resumeFromRam,
	output bwpc_state_t powerState
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [BWPC_NUM_WAKE:0] syncA;
	logic [BWPC_NUM_WAKE:0] syncB;
	logic [BWPC_NUM_WAKE:0] next_syncA;
	logic [BWPC_NUM_WAKE:0] next_syncB;

	always_comb
	begin
		next_syncA = {acPresent, ~wakePins};
		next_syncB = syncA;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncA <= '0;
			syncB <= '0;
		end
		else
		begin
			syncA <= next_syncA;
			syncB <= next_syncB;
		end
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	// standby-domain state
	bwpc_state_t state;
	bwpc_state_t next_state;
	bwpc_state_t lastState;
	bwpc_state_t next_lastState;
	logic acSeen;
	logic next_acSeen;
	logic next_resume;

	// ------------------------------------------------------------
	// wake qualification
	// ------------------------------------------------------------
	logic [BWPC_NUM_WAKE-1:0] wakeReq;
	logic acNow;
	logic wakeHit;
	logic isSleep;
	logic isS3;
	logic isS45;
	logic isOff;

	assign wakeReq = syncB[BWPC_NUM_WAKE-1:0];
	assign acNow = syncB[BWPC_NUM_WAKE];

	always_comb
	begin
		isS3 = (state == BWPC_S3);
		isS45 = (state == BWPC_S4) || (state == BWPC_S5);
		isOff = (state == BWPC_OFF);
		isSleep = isS3 || isS45;
		wakeHit = 1'b0;
		if (isSleep)
		begin
			if (isS3 && (wakeReq[BWPC_W_USB] || wakeReq[BWPC_W_PS2]))
				wakeHit = 1'b1;
			if (wakeReq[BWPC_W_PCIE] || wakeReq[BWPC_W_BTN])
				wakeHit = 1'b1;
			if ((wakeReq[BWPC_W_NET] || (wakeReq[BWPC_W_PME] && cfg.pm_event_wake_enable))
				&& (state != BWPC_S5 || cfg.softOffWakeEnable))
				wakeHit = 1'b1;
		end
		if (isOff && wakeReq[BWPC_W_BTN])
			wakeHit = 1'b1;
	end

	// ------------------------------------------------------------
	// power state machine
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_lastState = lastState;
		next_acSeen = acNow;
		next_resume = 1'b0;
		if (!acNow)
		begin
			next_state = BWPC_OFF;
		end
		else if (!acSeen)
		begin
			unique case (cfg.restorePolicy)
				BWPC_POL_ON: next_state = BWPC_S0;
				BWPC_POL_LAST: next_state = (lastState == BWPC_S0) ? BWPC_S0 : BWPC_S5;
				default: next_state = BWPC_S5;
			endcase
		end
		else if (state == BWPC_S0)
		begin
			if (sleepCmdValid)
			begin
				unique case (sleepCmd)
					BWPC_CMD_S3: next_state = BWPC_S3;
					BWPC_CMD_S4: next_state = BWPC_S4;
					BWPC_CMD_S5: next_state = BWPC_S5;
					default: next_state = BWPC_S0;
				endcase
			end
		end
		else if (wakeHit)
		begin
			next_state = BWPC_S0;
			next_resume = isS3;
		end
		if (acNow && acSeen)
			next_lastState = state;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= BWPC_OFF;
			lastState <= BWPC_OFF;
			acSeen <= 1'b0;
		end
		else
		begin
			state <= next_state;
			lastState <= next_lastState;
			acSeen <= next_acSeen;
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	bwpc_out_t next_outs;
	logic next_resumeFromRam;

	always_comb
	begin
		next_outs.fanOn = (next_state == BWPC_S0);
		next_outs.mainSupplyOn = (next_state == BWPC_S0);
		next_outs.ledGreen = (next_state == BWPC_S0);
		next_outs.ledAmber = (next_state == BWPC_S3);
		next_outs.standbyLed = 1'b1;
		next_resumeFromRam = next_resume;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			outs <= '0;
			resumeFromRam <= 1'b0;
			powerState <= BWPC_OFF;
		end
		else
		begin
			outs <= next_outs;
			resumeFromRam <= next_resumeFromRam;
			powerState <= next_state;
		end
	end

endmodule : bwpc_top

// ==== test/bwpc_partner.sv ====
/*
 wake source model: holds a requested wake pin low for a few cycles.
 assumes bench pulses wakeReq for one cycle.
*/
`timescale 1ns/10ps
module bwpc_partner
	import bwpc_pkg::*;
(
	input wire logic clk,
	input wire logic [5:0] wakeReq,
	output bwpc_wake_t wakePins
);
	logic [5:0] held = 6'h00;
	logic [2:0] cnt = 3'h0;
	always @(posedge clk)
	begin
		if (wakeReq != 6'h00)
		begin
			held <= wakeReq;
			cnt <= 3'h5;
		end
		else if (cnt != 3'h0)
			cnt <= cnt - 3'h1;
		else
			held <= 6'h00;
	end
	assign wakePins = ~held;
endmodule : bwpc_partner

// ==== test/bwpc_chk.sv ====
/*
 port checker for bwpc_top.
 assumes the bind below.
*/
`timescale 1ns/10ps
module bwpc_chk
	import bwpc_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire bwpc_wake_t wakePins,
	input wire logic sleepCmdValid,
	input wire logic [1:0] sleepCmd,
	input wire bwpc_out_t outs,
	input wire logic resumeFromRam,
	input wire bwpc_state_t powerState
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_fanOn; powerState == BWPC_S0 |-> outs.fanOn; endproperty
	a_fanOn: assert property (p_fanOn) else $error("fan off in S0");
	property p_fanOff; powerState != BWPC_S0 |-> !outs.fanOn; endproperty
	a_fanOff: assert property (p_fanOff) else $error("fan on out of S0");
	property p_offCmd; powerState == BWPC_S0 && sleepCmdValid && sleepCmd == BWPC_CMD_S5
		|=> powerState == BWPC_S5 && !outs.mainSupplyOn; endproperty
	a_offCmd: assert property (p_offCmd) else $error("off command not taken");
	property p_s3; powerState == BWPC_S3 |-> outs.ledAmber && !outs.mainSupplyOn; endproperty
	a_s3: assert property (p_s3) else $error("bad S3 outputs");
	property p_resume; resumeFromRam |-> $past(powerState) == BWPC_S3; endproperty
	a_resume: assert property (p_resume) else $error("resume not from S3");
	property p_stby; $past(arst_n) |-> outs.standbyLed; endproperty
	a_stby: assert property (p_stby) else $error("standby led dark");
	property p_single; resumeFromRam |=> !resumeFromRam; endproperty
	a_single: assert property (p_single) else $error("resume pulse too long");
	property p_pcie; $fell(wakePins.pcieWake_n) && powerState inside {BWPC_S3, BWPC_S4,
		BWPC_S5} |-> ##[1:4] powerState == BWPC_S0; endproperty
	a_pcie: assert property (p_pcie) else $error("pcie wake lost");
endmodule : bwpc_chk
bind bwpc_top bwpc_chk u_chk (.clk(clk), .arst_n(arst_n), .wakePins(wakePins),
	.sleepCmdValid(sleepCmdValid), .sleepCmd(sleepCmd), .outs(outs),
	.resumeFromRam(resumeFromRam), .powerState(powerState));

// ==== test/test_board_wake_power_controller.sv ====
/*
 bench for bwpc_top with wake source model.
 assumes checker bound to dut.
*/
`timescale 1ns/10ps
module test_board_wake_power_controller
	import bwpc_pkg::*;
;
	logic clk = 1'b0, arst_n = 1'b0, sleepCmdValid = 1'b0, acPresent = 1'b1;
	logic [1:0] sleepCmd = 2'h0;
	logic [5:0] wakeReq = 6'h00;
	bwpc_cfg_t cfg = {2'h0, BWPC_POL_ON};
	bwpc_wake_t wakePins;
	bwpc_out_t outs;
	logic resumeFromRam;
	bwpc_state_t powerState;
	int num_errors = 0, n_compared = 0, nResume = 0;
	bwpc_top dut (.clk(clk), .arst_n(arst_n), .wakePins(wakePins),
		.sleepCmdValid(sleepCmdValid), .sleepCmd(sleepCmd), .acPresent(acPresent),
		.cfg(cfg), .outs(outs), .resumeFromRam(resumeFromRam), .powerState(powerState));
	bwpc_partner u_src (.clk(clk), .wakeReq(wakeReq), .wakePins(wakePins));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (resumeFromRam === 1'b1) nResume++;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic st(input string nm, input bwpc_state_t s, input logic [4:0] o);
		chk(nm, 8'(s), 8'(powerState));
		chk(nm, 8'(o), 8'(outs));
	endtask : st
	task automatic cmd(input logic [1:0] c);
		@(posedge clk) #1 sleepCmd = c;
		sleepCmdValid = 1'b1;
		@(posedge clk) #1 sleepCmdValid = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : cmd
	task automatic wake(input int w);
		@(posedge clk) #1 wakeReq = 6'(w);
		@(posedge clk) #1 wakeReq = 6'h00;
		repeat (8) @(posedge clk);
		#1;
	endtask : wake
	task automatic t_s3;
		cmd(BWPC_CMD_S3);
		st("s3", BWPC_S3, 5'h03);
		wake(1 << BWPC_W_USB | 1 << BWPC_W_PS2);
		st("s3 wake", BWPC_S0, 5'h1D);
		wake(1 << BWPC_W_USB);
		chk("resume", 8'h01, 8'(nResume));
	endtask : t_s3
	task automatic t_s5;
		cfg.pm_event_wake_enable = 1'b1;
		cmd(BWPC_CMD_S5);
		st("s5", BWPC_S5, 5'h01);
		wake(1 << BWPC_W_PME);
		st("s5 pme", BWPC_S5, 5'h01);
		cfg.softOffWakeEnable = 1'b1;
		wake(1 << BWPC_W_PME);
		st("s5 wake", BWPC_S0, 5'h1D);
	endtask : t_s5
	task automatic t_s4;
		cmd(BWPC_CMD_S4);
		wake(1 << BWPC_W_USB);
		st("s4 usb", BWPC_S4, 5'h01);
		wake(1 << BWPC_W_NET | 1 << BWPC_W_PCIE);
		st("s4 wake", BWPC_S0, 5'h1D);
		chk("cold", 8'h01, 8'(nResume));
	endtask : t_s4
	task automatic ac_cycle(input logic [1:0] pol);
		cfg.restorePolicy = pol;
		acPresent = 1'b0;
		repeat (6) @(posedge clk);
		#1 st("ac lost", BWPC_OFF, 5'h01);
		acPresent = 1'b1;
		repeat (8) @(posedge clk);
		#1;
	endtask : ac_cycle
	task automatic t_ac;
		ac_cycle(BWPC_POL_LAST);
		st("ac back", BWPC_S0, 5'h1D);
		cmd(BWPC_CMD_S3);
		ac_cycle(BWPC_POL_LAST);
		st("ac back s3", BWPC_S5, 5'h01);
		wake(1 << BWPC_W_BTN);
		st("btn wake", BWPC_S0, 5'h1D);
		ac_cycle(BWPC_POL_OFF);
		st("ac back off", BWPC_S5, 5'h01);
	endtask : t_ac
	task automatic finish_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (4) @(posedge clk);
		#1 arst_n = 1'b1;
		repeat (8) @(posedge clk);
		#1 st("boot", BWPC_S0, 5'h1D);
		t_s3();
		t_s5();
		t_s4();
		t_ac();
		finish_test();
	end
	initial
	begin
		#4000 num_errors++;
		finish_test();
	end
endmodule : test_board_wake_power_controller
